// ===== design/ebc_pkg.sv
// package: constants and carriers for the burst rom / muxed io bus engine
package ebc_pkg;
  localparam int AW = 24;
  localparam int DW = 16;
  localparam logic [2:0] MPX_FIRST = 3'h3;
  localparam logic [2:0] BURST_LAST = 3'h1;
  localparam logic [5:0] BURST_MIN_WORDS = 6'h04;
  localparam logic [5:0] WORD_ONE = 6'h01;
  localparam logic [2:0] CNT_ONE = 3'h1;
  localparam logic [AW-1:0] STEP8 = 24'h000001;
  localparam logic [AW-1:0] STEP16 = 24'h000002;

  // gray codes along idle, address, data, burst
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_CSXPRE  = 4'h1,
    ST_MA1     = 4'h3,
    ST_MAW     = 4'h2,
    ST_MA2     = 4'h6,
    ST_T1      = 4'h7,
    ST_T2      = 4'h5,
    ST_TW      = 4'h4,
    ST_T3      = 4'hc,
    ST_BST     = 4'hd,
    ST_CSXPOST = 4'hf
  } ebc_state_t;

  typedef struct packed {
    logic [2:0]    area;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [1:0]    be;
    logic          write;
    logic          cpu;
  } ebc_req_t;

  typedef struct packed {
    logic [7:0]      area_width_high_bit;
    logic [7:0]      three_state_access_bit;
    logic [7:0][2:0] wait_count;
    logic            wait_pin_en;
    logic [7:0]      pre_access_cs_extend_bit;
    logic [7:0]      post_access_cs_extend_bit;
    logic [7:0]      read_negate_timing_bit;
    logic [1:0]      burst_space_enable;
    logic [1:0][2:0] burst_cycle_len;
    logic [1:0][1:0] burst_word_count;
    logic [4:0]      muxed_space_enable;
    logic            address_phase_extend;
  } ebc_cfg_t;

  typedef struct packed {
    logic [7:0]    chip_select_n;
    logic          addr_strobe_hold_n;
    logic          bus_cycle_start_n;
    logic          rd_n;
    logic          rd_wr;
    logic          upper_byte_write_n;
    logic          lower_byte_write_n;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
    logic [1:0]    data_oe_n;
  } ebc_pins_t;

  localparam ebc_pins_t PINS_IDLE = '{
    chip_select_n: 8'hff, addr_strobe_hold_n: 1'b1,
    bus_cycle_start_n: 1'b1, rd_n: 1'b1, rd_wr: 1'b1,
    upper_byte_write_n: 1'b1, lower_byte_write_n: 1'b1,
    addr: '0, data: '0, data_oe_n: 2'h3};

  typedef struct packed {
    ebc_state_t    st;
    ebc_req_t      req;
    logic [2:0]    cnt;
    logic [5:0]    left;
    logic          w16;
    logic          burst;
    logic          mpx;
    ebc_pins_t     pins;
    logic [DW-1:0] rdata;
    logic          rvalid;
    logic          done;
    logic          ready;
  } ebc_regs_t;

  localparam ebc_regs_t REGS_RESET = '{
    st: ST_IDLE, req: '0, cnt: '0, left: '0, w16: 1'b0,
    burst: 1'b0, mpx: 1'b0, pins: PINS_IDLE, rdata: '0,
    rvalid: 1'b0, done: 1'b0, ready: 1'b1};
endpackage

// ===== design/ebc_bus_engine.sv
// external bus engine: burst rom reads and address/data muxed io cycles
`timescale 1ns/10ps
`default_nettype none

module ebc_bus_engine (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // request side
  input  wire logic              req_valid_in,
  input  wire ebc_pkg::ebc_req_t req_in,
  output logic                   req_ready_out,
  output logic [15:0]            rdata_out,
  output logic                   rvalid_out,
  output logic                   done_out,
  // configuration
  input  wire ebc_pkg::ebc_cfg_t cfg_in,
  // external pins
  input  wire logic              wait_n_in,
  input  wire logic [15:0]       data_in,
  output ebc_pkg::ebc_pins_t     pins_out
);

  ebc_pkg::ebc_regs_t r;
  ebc_pkg::ebc_regs_t n;
  logic [2:0]         sa;
  logic               s_burst;
  logic               s_mpx;
  logic [2:0]         a;
  logic               last;
  logic               pin_wait;
  logic [23:0]        step;
  logic               bi;
  logic               mpx_any;
  localparam logic [2:0] CNT1 = ebc_pkg::CNT_ONE;

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    n.rvalid = 1'b0;
    n.done = 1'b0;
    last = 1'b0;
    sa = req_in.area;
    a = r.req.area;
    bi = a[0];
    mpx_any = |cfg_in.muxed_space_enable;
    // cpu reads only; everything else stays a basic cycle
    s_burst = req_in.cpu && !req_in.write && (sa <= ebc_pkg::BURST_LAST)
              && cfg_in.burst_space_enable[sa[0]];
    s_mpx = (sa >= ebc_pkg::MPX_FIRST)
            && cfg_in.muxed_space_enable[3'(sa - ebc_pkg::MPX_FIRST)];
    pin_wait = cfg_in.wait_pin_en && !wait_n_in;
    step = r.w16 ? ebc_pkg::STEP16 : ebc_pkg::STEP8;
    case (r.st)
      ebc_pkg::ST_IDLE: begin
        if (req_valid_in) begin
          n.req = req_in;
          n.burst = s_burst;
          n.mpx = s_mpx;
          n.w16 = !cfg_in.area_width_high_bit[sa];
          n.pins.addr = req_in.addr;
          if (cfg_in.pre_access_cs_extend_bit[sa]) begin
            n.st = ebc_pkg::ST_CSXPRE;
          end else if (s_mpx) begin
            n.st = ebc_pkg::ST_MA1;
          end else begin
            n.st = ebc_pkg::ST_T1;
          end
        end
      end
      ebc_pkg::ST_CSXPRE: begin
        n.st = r.mpx ? ebc_pkg::ST_MA1 : ebc_pkg::ST_T1;
      end
      ebc_pkg::ST_MA1: begin
        // address cycles ignore every wait setting
        n.st = cfg_in.address_phase_extend ? ebc_pkg::ST_MAW
                                           : ebc_pkg::ST_MA2;
      end
      ebc_pkg::ST_MAW: begin
        n.st = ebc_pkg::ST_MA2;
      end
      ebc_pkg::ST_MA2: begin
        n.st = ebc_pkg::ST_T1;
      end
      ebc_pkg::ST_T1: begin
        n.st = ebc_pkg::ST_T2;
      end
      ebc_pkg::ST_T2: begin
        if (!cfg_in.three_state_access_bit[a]) begin
          last = 1'b1;
        end else if (cfg_in.wait_count[a] != '0) begin
          n.cnt = cfg_in.wait_count[a];
          n.st = ebc_pkg::ST_TW;
        end else if (pin_wait) begin
          n.st = ebc_pkg::ST_TW;
        end else begin
          n.st = ebc_pkg::ST_T3;
        end
      end
      ebc_pkg::ST_TW: begin
        if (r.cnt > CNT1) begin
          n.cnt = r.cnt - ebc_pkg::CNT_ONE;
        end else if (r.cnt == CNT1) begin
          n.cnt = '0;
          n.st = pin_wait ? ebc_pkg::ST_TW : ebc_pkg::ST_T3;
        end else if (!pin_wait) begin
          n.st = ebc_pkg::ST_T3;
        end
      end
      ebc_pkg::ST_T3: begin
        last = 1'b1;
      end
      ebc_pkg::ST_BST: begin
        // no wait sampling here at all
        if (r.cnt != '0) begin
          n.cnt = r.cnt - ebc_pkg::CNT_ONE;
        end else begin
          n.rdata = data_in;
          n.rvalid = 1'b1;
          if (r.left == ebc_pkg::WORD_ONE) begin
            n.st = ebc_pkg::ST_IDLE;
            n.done = 1'b1;
          end else begin
            n.left = r.left - ebc_pkg::WORD_ONE;
            n.cnt = cfg_in.burst_cycle_len[bi];
            n.pins.addr = r.pins.addr + step;
          end
        end
      end
      ebc_pkg::ST_CSXPOST: begin
        n.st = ebc_pkg::ST_IDLE;
        n.done = 1'b1;
      end
      default: begin
        n = ebc_pkg::REGS_RESET;
      end
    endcase

    // early negation: park the word while rd_n is still low
    if (n.st == ebc_pkg::ST_T3 && r.st != ebc_pkg::ST_T3
        && !r.req.write) begin
      n.req.wdata = data_in;
    end

    if (last) begin
      if (!r.req.write) begin
        n.rdata = r.pins.rd_n ? r.req.wdata : data_in;
        n.rvalid = 1'b1;
      end
      if (r.burst) begin
        // full access counts as the first word
        n.left = (ebc_pkg::BURST_MIN_WORDS
                  << cfg_in.burst_word_count[bi])
                 - ebc_pkg::WORD_ONE;
        n.cnt = cfg_in.burst_cycle_len[bi];
        n.pins.addr = r.pins.addr + step;
        n.st = ebc_pkg::ST_BST;
      end else if (cfg_in.post_access_cs_extend_bit[a]) begin
        n.st = ebc_pkg::ST_CSXPOST;
      end else begin
        n.st = ebc_pkg::ST_IDLE;
        n.done = 1'b1;
      end
    end

    // pin image for the state being entered
    n.ready = (n.st == ebc_pkg::ST_IDLE);
    n.pins.chip_select_n = '1;
    n.pins.addr_strobe_hold_n = 1'b1;
    n.pins.bus_cycle_start_n = 1'b1;
    n.pins.rd_n = 1'b1;
    n.pins.rd_wr = 1'b1;
    n.pins.upper_byte_write_n = 1'b1;
    n.pins.lower_byte_write_n = 1'b1;
    n.pins.data_oe_n = 2'h3;
    if (n.st != ebc_pkg::ST_IDLE) begin
      n.pins.chip_select_n[n.req.area] = 1'b0;
      n.pins.rd_wr = !n.req.write;
    end
    case (n.st)
      ebc_pkg::ST_MA1, ebc_pkg::ST_MAW, ebc_pkg::ST_MA2: begin
        n.pins.data = n.pins.addr[15:0];
        n.pins.data_oe_n = {!n.w16, 1'b0};
        n.pins.bus_cycle_start_n = (n.st != ebc_pkg::ST_MA1);
        n.pins.addr_strobe_hold_n = (n.st == ebc_pkg::ST_MA2);
      end
      ebc_pkg::ST_T1, ebc_pkg::ST_T2, ebc_pkg::ST_TW,
      ebc_pkg::ST_T3: begin
        n.pins.bus_cycle_start_n = !(n.st == ebc_pkg::ST_T1 && !n.mpx);
        // once muxed space exists the pin never strobes here
        n.pins.addr_strobe_hold_n = mpx_any
                                  || n.st == ebc_pkg::ST_T3;
        if (n.req.write) begin
          n.pins.data = n.req.wdata;
          n.pins.data_oe_n = {!n.w16, 1'b0};
          if (n.st == ebc_pkg::ST_T2 || n.st == ebc_pkg::ST_TW) begin
            n.pins.upper_byte_write_n = !(n.w16 && n.req.be[1]);
            n.pins.lower_byte_write_n = !n.req.be[0];
          end
        end else if (n.st != ebc_pkg::ST_T1) begin
          // burst reads keep the default negation point
          n.pins.rd_n = n.st == ebc_pkg::ST_T3 && !n.burst
                      && cfg_in.read_negate_timing_bit[n.req.area];
        end
      end
      ebc_pkg::ST_BST: begin
        n.pins.rd_n = 1'b0;
      end
      default: begin
        n.pins.data_oe_n = 2'h3;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= ebc_pkg::REGS_RESET;
    end else begin
      r <= n;
    end
  end

  assign req_ready_out = r.ready;
  assign rdata_out = r.rdata;
  assign rvalid_out = r.rvalid;
  assign done_out = r.done;
  assign pins_out = r.pins;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  logic [3:0] bst_len_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bst_len_r <= '0;
    end else if (r.st == ebc_pkg::ST_BST && r.cnt != '0) begin
      bst_len_r <= bst_len_r + 4'h1;
    end else begin
      bst_len_r <= '0;
    end
  end

  chk_burst_no_wait: assert property (
    r.st == ebc_pkg::ST_BST |=> r.st inside {ebc_pkg::ST_BST,
                                             ebc_pkg::ST_IDLE})
    else $error("burst cycle left for a wait or extension");
  chk_burst_cycle_len: assert property (
    bst_len_r <= 4'h7)
    else $error("burst cycle longer than eight clocks");
  chk_burst_addr_step: assert property (
    (r.st == ebc_pkg::ST_BST && r.cnt == '0
     && r.left != ebc_pkg::WORD_ONE)
    |=> r.pins.addr == $past(r.pins.addr) + $past(step))
    else $error("burst address did not step one word");
  chk_burst_strobes: assert property (
    r.st == ebc_pkg::ST_BST |-> !r.pins.rd_n
                                && !r.pins.chip_select_n[r.req.area])
    else $error("burst strobes negated early");
  chk_mpx_addr_pins: assert property (
    r.st == ebc_pkg::ST_MA1 |-> !r.pins.data_oe_n[0]
      && r.pins.data[7:0] == r.pins.addr[7:0])
    else $error("muxed pins not driving the address");
  chk_addr_extend: assert property (
    (r.st == ebc_pkg::ST_MA1 && cfg_in.address_phase_extend)
    |=> r.st == ebc_pkg::ST_MAW ##1 r.st == ebc_pkg::ST_MA2
        ##1 r.st == ebc_pkg::ST_T1)
    else $error("address extension cycle missing");
  chk_hold_only: assert property (
    ((|cfg_in.muxed_space_enable) && r.st == ebc_pkg::ST_T1)
    |-> r.pins.addr_strobe_hold_n)
    else $error("strobe pin acted as address strobe");
  chk_write_bytes: assert property (
    !r.pins.lower_byte_write_n |-> r.req.write && r.req.be[0])
    else $error("lower write strobe without lower data");
  chk_burst_no_post: assert property (
    r.st == ebc_pkg::ST_BST |=> r.st != ebc_pkg::ST_CSXPOST)
    else $error("extension after burst cycles");

  cov_burst_read: cover property (
    r.st == ebc_pkg::ST_T3 ##1 r.st == ebc_pkg::ST_BST);
  cov_mpx_extend: cover property (
    r.st == ebc_pkg::ST_MAW ##1 r.st == ebc_pkg::ST_MA2);
  cov_wait_cycles: cover property (
    r.st == ebc_pkg::ST_TW [*3]);

endmodule

`default_nettype wire

// ===== testbench/ebc_far_model.sv
// far-side model: page rom or muxed peripheral answering the bus engine
`timescale 1ns/10ps
`default_nettype none
module ebc_far_model (
  // clock
  input  wire logic               clk_in,
  // bus pins and stall length
  input  wire ebc_pkg::ebc_pins_t pins_in,
  input  wire logic [2:0]         stall_in,
  // answers
  output logic [15:0]             data_out,
  output logic                    wait_n_out
);
  logic [15:0] last_r = 16'h0000;
  logic [2:0]  stall_r = 3'h0;

  // word follows the address so page steps are visible;
  // a released bus shows the inverse of the last word, never a held value
  always_comb begin
    if (!pins_in.rd_n) begin
      data_out = {pins_in.addr[7:0] ^ 8'h5a, pins_in.addr[7:0]};
    end else begin
      data_out = ~last_r;
    end
  end

  always_ff @(posedge clk_in) begin
    last_r <= data_out;
    if (!pins_in.bus_cycle_start_n) begin
      stall_r <= stall_in;
    end else if (stall_r != 3'h0) begin
      stall_r <= stall_r - 3'h1;
    end
  end

  // slow answer: wait request held for stall_in cycles
  assign wait_n_out = (stall_r == 3'h0);
endmodule
`default_nettype wire

// ===== testbench/burst_rom_and_muxed_io_bus_tb.sv
// self-checking bench for the burst rom / muxed io bus engine
`timescale 1ns/10ps
`default_nettype none
module burst_rom_and_muxed_io_bus_tb;
  logic               clk_in = 1'b0;
  logic               rst_n_in = 1'b0;
  logic               req_valid_in = 1'b0;
  ebc_pkg::ebc_req_t  req_in = '0;
  ebc_pkg::ebc_cfg_t  cfg_in = '0;
  logic [2:0]         stall = 3'h0;
  logic               req_ready_out, rvalid_out, done_out, wait_n_in;
  logic [15:0]        rdata_out, data_in;
  ebc_pkg::ebc_pins_t pins_out, snap;
  logic [23:0]        nxt_a;
  logic               w8, uw, lw, got;
  int                 errors = 0, n_compared = 0, cyc, nrv, ahl, base, c;
  int                 nrd;

  always #2 clk_in = ~clk_in;

  ebc_bus_engine u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .req_valid_in(req_valid_in), .req_in(req_in),
    .req_ready_out(req_ready_out), .rdata_out(rdata_out),
    .rvalid_out(rvalid_out), .done_out(done_out), .cfg_in(cfg_in),
    .wait_n_in(wait_n_in), .data_in(data_in), .pins_out(pins_out));

  ebc_far_model u_far (.clk_in(clk_in), .pins_in(pins_out),
    .stall_in(stall), .data_out(data_in), .wait_n_out(wait_n_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // one whole bus cycle; entered and left just after a falling edge
  task automatic xfer(input logic [2:0] ar, input logic [23:0] ad,
                      input logic wr, input logic cp, input logic [1:0] be);
    req_in = '{ar, ad, 16'hc3a5, be, wr, cp};
    w8 = cfg_in.area_width_high_bit[ar];
    nxt_a = ad;
    cyc = 0;
    nrv = 0;
    ahl = 0;
    nrd = 0;
    uw = 1'b0;
    lw = 1'b0;
    got = 1'b0;
    req_valid_in = 1'b1;
    @(posedge clk_in);
    do begin
      @(negedge clk_in);
      if (cyc == 0) req_valid_in = 1'b0;
      cyc++;
      if (!pins_out.addr_strobe_hold_n) ahl++;
      if (!pins_out.rd_n) nrd++;
      if (!pins_out.upper_byte_write_n) uw = 1'b1;
      if (!pins_out.lower_byte_write_n) lw = 1'b1;
      if (!pins_out.bus_cycle_start_n && !got) snap = pins_out;
      if (!pins_out.bus_cycle_start_n) got = 1'b1;
      if (rvalid_out) begin
        nrv++;
        if (w8) check(rdata_out[7:0], nxt_a[7:0]);
        else check(rdata_out, {nxt_a[7:0] ^ 8'h5a, nxt_a[7:0]});
        nxt_a = nxt_a + (w8 ? 24'h1 : 24'h2);
      end
    end while (done_out !== 1'b1 && cyc < 1000);
    // a cycle that never ends fails here
    check({done_out, req_ready_out, ~snap.chip_select_n},
          {2'b11, 8'h01 << ar});
  endtask

  initial begin
    repeat (8) @(negedge clk_in);
    rst_n_in = 1'b1;
    @(negedge clk_in);
    xfer(3'h2, 24'h000100, 1'b0, 1'b1, 2'h3);
    base = cyc;
    check(nrv, 1);
    check(ahl, 2);
    cfg_in.three_state_access_bit[2] = 1'b1;
    cfg_in.wait_count[2] = 3'h2;
    xfer(3'h2, 24'h000102, 1'b0, 1'b1, 2'h3);
    check(cyc, base + 3);
    ////////////////////////////////////////////////////////////////////
    // burst reads: post extension and read-negate set but must not stretch; pre extension adds one cycle
    cfg_in.burst_space_enable = 2'h1;
    cfg_in.pre_access_cs_extend_bit[0] = 1'b1;
    cfg_in.post_access_cs_extend_bit[0] = 1'b1;
    cfg_in.read_negate_timing_bit[0] = 1'b1;
    for (c = 0; c < 4; c++) begin
      cfg_in.burst_word_count[0] = c[1:0];
      cfg_in.burst_cycle_len[0] = 3'(2 * c + 1);
      xfer(3'h0, 24'h000040, 1'b0, 1'b1, 2'h3);
      check(nrv, 4 << c);
      check(cyc, base + 1 + ((4 << c) - 1) * (2 * c + 2));
    end
    xfer(3'h0, 24'h000040, 1'b0, 1'b0, 2'h3);
    check(nrv, 1);
    check(cyc, base + 2);
    xfer(3'h0, 24'h000044, 1'b1, 1'b1, 2'h3);
    check({uw, lw, cyc[7:0]}, {2'b11, 8'(base + 2)});
    cfg_in.burst_word_count[0] = 2'h0;
    cfg_in.burst_cycle_len[0] = 3'h1;
    cfg_in.three_state_access_bit[0] = 1'b1;
    cfg_in.wait_count[0] = 3'h2;
    xfer(3'h0, 24'h000040, 1'b0, 1'b1, 2'h3);
    check(cyc, base + 10);
    check(nrd, 10);
    cfg_in.area_width_high_bit[0] = 1'b1;
    xfer(3'h0, 24'h000081, 1'b0, 1'b1, 2'h3);
    check(nrv, 4);
    ////////////////////////////////////////////////////////////////////
    // muxed space on area 4 only
    cfg_in.muxed_space_enable = 5'h02;
    xfer(3'h2, 24'h000104, 1'b0, 1'b1, 2'h3);
    check(ahl, 0);
    xfer(3'h4, 24'h12a5c3, 1'b0, 1'b1, 2'h3);
    check(cyc, base + 2);
    check(ahl, 1);
    check({snap.data_oe_n, snap.data}, 18'h0a5c3);
    check(snap.addr, 24'h12a5c3);
    cfg_in.address_phase_extend = 1'b1;
    xfer(3'h4, 24'h12a5c3, 1'b0, 1'b1, 2'h3);
    check(cyc, base + 3);
    check(ahl, 2);
    cfg_in.area_width_high_bit[4] = 1'b1;
    xfer(3'h4, 24'h12a5c3, 1'b1, 1'b1, 2'h3);
    check({snap.data_oe_n[0], snap.data[7:0]}, 9'h0c3);
    check({uw, lw}, 2'b01);
    cfg_in.area_width_high_bit[4] = 1'b0;
    xfer(3'h4, 24'h12a5c4, 1'b1, 1'b1, 2'h2);
    check({uw, lw}, 2'b10);
    cfg_in.three_state_access_bit[4] = 1'b1;
    cfg_in.wait_count[4] = 3'h3;
    cfg_in.pre_access_cs_extend_bit[4] = 1'b1;
    cfg_in.post_access_cs_extend_bit[4] = 1'b1;
    xfer(3'h4, 24'h000222, 1'b0, 1'b1, 2'h3);
    check(cyc, base + 9);
    cfg_in.read_negate_timing_bit[4] = 1'b1;
    xfer(3'h4, 24'h000224, 1'b0, 1'b1, 2'h3);
    check({cyc[7:0], nrd[7:0]}, {8'(base + 9), 8'h04});
    xfer(3'h5, 24'h000010, 1'b0, 1'b1, 2'h3);
    check(cyc, base);
    // slow far side: pin wait stretches the access
    cfg_in.wait_pin_en = 1'b1;
    stall = 3'h3;
    xfer(3'h2, 24'h000106, 1'b0, 1'b1, 2'h3);
    check(cyc, base + 4);
    conclude();
  end

  // whole run is well under this span
  initial begin
    #80000;
    errors++;
    conclude();
  end
endmodule
`default_nettype wire
